// ### hdl/card_slot_status_control_reg.v
// Primary status and control register of one main card slot.
`timescale 1ns/1ps
`default_nettype none
`include "card_slot_regs.vh"
module card_slot_status_control_reg (
    input wire clk_sys,                 // System clock, 200 MHz.
    input wire rst_n,                   // Synchronous reset, active low.
    input wire regWrite,                // One-cycle pulse: control byte written.
    input wire [7:0] regWriteData,      // Byte written to the control view.
    input wire statusReadDone,          // One-cycle pulse: status byte fully sent.
    input wire cardPresent,             // Debounced card presence level.
    input wire earlyAnswerEvent,        // Card answered too early during answer.
    input wire muteEvent,               // Card did not answer in time.
    input wire overloadEvent,           // Overload or overheat detected.
    input wire supplyFaultEvent,        // Supply supervisor fault pulse.
    input wire startBitDetected,        // Start bit seen on the card line.
    input wire [1:0] lowpowerClockSetting, // Clock choice for power-down.
    input wire [1:0] clockDividerSetting,  // Clock choice for normal running.
    input wire hostIoIn,                // Level on the host I/O line.
    input wire cardIoIn,                // Level on the card I/O line.
    output reg [7:0] statusByte,        // Status view presented to the bus.
    output reg interruptRequest_n,      // Interrupt, active low.
    output reg [1:0] supplyLevel,       // Card supply level code.
    output reg supplyOn,                // Card supply switched on.
    output reg [1:0] pageViewSelect,    // Secondary page view choice.
    output reg warmResetActive,         // Warm reset in progress.
    output reg coldStartPulse,          // One-cycle start of activation.
    output reg deactivatePulse,         // One-cycle start of deactivation.
    output reg cardClock,               // Card clock pin.
    output reg hostIoOut,               // Host I/O drive value.
    output reg hostIoOe,                // Host I/O driven when high.
    output reg cardIoOut,               // Card I/O drive value.
    output reg cardIoOe                 // Card I/O driven when high.
);
    // Control view storage; the status view never shares these bits.
    reg lowVoltageSel_reg;    // 1.8 V select.
    reg highVoltageSel_reg;   // 5 V versus 3 V select.
    reg ioPassEnable_reg;     // I/O pass-through enable.
    reg [1:0] pageView_reg;   // Secondary page view.
    reg clockStopApply_reg;   // Low-power clock choice in force.
    reg warmReset_reg;        // Warm reset request.
    reg start_reg;            // Session start bit.
    reg active_reg;           // Card powered in a session.
    reg presentDly_reg;       // Presence one cycle ago for edge detection.
    reg active_next;          // Next session state.

    wire earlyFlag;      // Early answer flag.
    wire muteFlag;       // Mute flag.
    wire overloadFlag;   // Overload flag.
    wire supplyFlag;     // Supply fault flag.
    wire presChgFlag;    // Presence change flag.
    wire clockFallback;  // Fallback clock in use.
    wire cardClockInt;   // Clock from the generator.

    // Presence edge in either direction.
    wire presenceEdge = cardPresent ^ presentDly_reg;

    // Start is refused unless the slot is healthy and a card is seated.
    wire startAllowed = !supplyFlag && !overloadFlag && cardPresent;

    // Writes carrying start set while idle and allowed.
    wire startAccept = regWrite && regWriteData[`CTL_START_BIT] && !start_reg
        && startAllowed;
    // Writes carrying start clear while a session runs.
    wire stopAccept = regWrite && !regWriteData[`CTL_START_BIT] && start_reg;

    // A session also ends on its own when the card leaves or a fault trips.
    wire forcedStop = start_reg && (!cardPresent || overloadEvent || supplyFaultEvent);

    // Clear only once the whole status byte has gone out.
    wire readClear = statusReadDone;

    // Read-clear flags; the set input wins over a clear in the same cycle.
    sticky_flag #(.RESET_VALUE(1'b0)) uEarly (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setEvent(earlyAnswerEvent && active_reg),
        .clearReq(readClear),
        .flag_reg(earlyFlag)
    );

    sticky_flag #(.RESET_VALUE(1'b0)) uMute (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setEvent(muteEvent && active_reg),
        .clearReq(readClear),
        .flag_reg(muteFlag)
    );

    sticky_flag #(.RESET_VALUE(1'b0)) uOverload (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setEvent(overloadEvent && active_reg),
        .clearReq(readClear),
        .flag_reg(overloadFlag)
    );

    // The supply flag comes up set after reset, as the supervisor has just released.
    sticky_flag #(.RESET_VALUE(1'b1)) uSupply (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setEvent(supplyFaultEvent),
        .clearReq(readClear),
        .flag_reg(supplyFlag)
    );

    sticky_flag #(.RESET_VALUE(1'b0)) uPresChg (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setEvent(presenceEdge),
        .clearReq(readClear),
        .flag_reg(presChgFlag)
    );

    // Card clock: low-power setting when stopped, divider otherwise.
    card_clock_gen uClock (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clockStopApply(clockStopApply_reg),
        .lowpowerSetting(lowpowerClockSetting),
        .dividerSetting(clockDividerSetting),
        .enable(active_reg),
        .cardClock_reg(cardClockInt),
        .fallback_reg(clockFallback)
    );

    // Session state follows accepted starts, stops and forced stops.
    always @* begin
        active_next = active_reg;
        if (startAccept) begin
            active_next = 1'b1;
        end else if (stopAccept || forcedStop) begin
            active_next = 1'b0;
        end
    end

    // Control view writes; status flags are untouched by any write.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            lowVoltageSel_reg <= 1'b0;
            highVoltageSel_reg <= 1'b0;
            ioPassEnable_reg <= 1'b0;
            pageView_reg <= 2'h0;
            clockStopApply_reg <= 1'b0;
            warmReset_reg <= 1'b0;
            start_reg <= 1'b0;
            active_reg <= 1'b0;
            presentDly_reg <= 1'b0;
        end else begin
            presentDly_reg <= cardPresent;
            active_reg <= active_next;
            if (regWrite) begin
                ioPassEnable_reg <= regWriteData[`CTL_IOEN_BIT];
                pageView_reg <= regWriteData[`CTL_PAGE_HI:`CTL_PAGE_LO];
                clockStopApply_reg <= regWriteData[`CTL_CLKSTOP_BIT];
                // The supply choice is frozen while a session runs.
                if (!start_reg) begin
                    lowVoltageSel_reg <= regWriteData[`CTL_LOWV_BIT];
                    highVoltageSel_reg <= regWriteData[`CTL_HIGHV_BIT];
                end
            end
            // Start bit stored only when accepted; cleared on any stop.
            if (startAccept) begin
                start_reg <= 1'b1;
            end else if (stopAccept || forcedStop) begin
                start_reg <= 1'b0;
            end
            // Warm reset: hardware clear beats a simultaneous set request.
            if (startBitDetected || muteEvent || !active_reg) begin
                warmReset_reg <= 1'b0;
            end else if (regWrite && regWriteData[`CTL_WARM_BIT]) begin
                warmReset_reg <= 1'b1;
            end
        end
    end

    // Registered outputs toward the bus, the regulator and the card.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            statusByte <= `STATUS_RESET;
            interruptRequest_n <= 1'b1;
            supplyLevel <= `SUPPLY_3V;
            supplyOn <= 1'b0;
            pageViewSelect <= 2'h0;
            warmResetActive <= 1'b0;
            coldStartPulse <= 1'b0;
            deactivatePulse <= 1'b0;
            cardClock <= 1'b0;
        end else begin
            // Status view built from live state and sticky flags.
            statusByte[`STS_ACTIVE_BIT] <= active_reg;
            statusByte[`STS_EARLY_BIT] <= earlyFlag;
            statusByte[`STS_MUTE_BIT] <= muteFlag;
            statusByte[`STS_OVERLOAD_BIT] <= overloadFlag;
            statusByte[`STS_SUPPLY_BIT] <= supplyFlag;
            statusByte[`STS_CLKFB_BIT] <= clockFallback;
            statusByte[`STS_PRESCHG_BIT] <= presChgFlag;
            statusByte[`STS_PRESENT_BIT] <= cardPresent;
            // Interrupt asserted while any event flag waits to be read.
            interruptRequest_n <= !(presChgFlag || supplyFlag || overloadFlag
                || muteFlag || earlyFlag);
            // Low voltage select overrides the high voltage select.
            if (lowVoltageSel_reg) begin
                supplyLevel <= `SUPPLY_1V8;
            end else if (highVoltageSel_reg) begin
                supplyLevel <= `SUPPLY_5V;
            end else begin
                supplyLevel <= `SUPPLY_3V;
            end
            supplyOn <= active_reg;
            pageViewSelect <= pageView_reg;
            warmResetActive <= warmReset_reg;
            coldStartPulse <= startAccept;
            deactivatePulse <= stopAccept || forcedStop;
            cardClock <= cardClockInt;
        end
    end

    // Half-duplex pass-through: a low on one side is copied as a drive low
    // on the other, unless this side is itself the one being driven. With
    // pass-through off both ends float and rely on their pull-ups.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            hostIoOut <= 1'b0;
            hostIoOe <= 1'b0;
            cardIoOut <= 1'b0;
            cardIoOe <= 1'b0;
        end else if (ioPassEnable_reg) begin
            cardIoOe <= !hostIoIn && !hostIoOe;
            hostIoOe <= !cardIoIn && !cardIoOe;
            cardIoOut <= 1'b0;
            hostIoOut <= 1'b0;
        end else begin
            cardIoOe <= 1'b0;
            hostIoOe <= 1'b0;
            cardIoOut <= 1'b0;
            hostIoOut <= 1'b0;
        end
    end
endmodule // card_slot_status_control_reg
`default_nettype wire

// ### hdl/card_slot_regs.vh
// Constants for the card slot status and control register pair.
// How it works
// - Status bit 7 shows active powered session.
// - Bit 6 flags early answer, read clears.
// - Bit 5 flags mute timeout, read clears.
// - Bit 4 flags overload or overheat, read clears.
// - Bit 3 flags supply supervisor fault, read clears.
// - Bit 2 shows power-down internal clock fallback.
// - Bit 1 flags insertion or extraction, read clears.
// - Bit 0 shows card present level.
// - Control bit 7 forces 1.8 V supply.
// - Control bit 6 connects host and card I/O.
// - Control bits 5:4 select secondary page view.
// - Clock stop set: use low-power clock setting.
// - Clock stop clear: use divider setting.
// - High voltage select with low clear: 5 V.
// - High voltage clear with low clear: 3 V.
// - Start only without faults and with card.
// - Warm reset bit cleared by start or mute.
// - Interrupt low while any event flag set.
`ifndef CARD_SLOT_REGS_VH
`define CARD_SLOT_REGS_VH

// Status view bit positions.
`define STS_ACTIVE_BIT 3'd7
`define STS_EARLY_BIT 3'd6
`define STS_MUTE_BIT 3'd5
`define STS_OVERLOAD_BIT 3'd4
`define STS_SUPPLY_BIT 3'd3
`define STS_CLKFB_BIT 3'd2
`define STS_PRESCHG_BIT 3'd1
`define STS_PRESENT_BIT 3'd0

// Control view bit positions.
`define CTL_LOWV_BIT 3'd7
`define CTL_IOEN_BIT 3'd6
`define CTL_PAGE_HI 3'd5
`define CTL_PAGE_LO 3'd4
`define CTL_CLKSTOP_BIT 3'd3
`define CTL_HIGHV_BIT 3'd2
`define CTL_WARM_BIT 3'd1
`define CTL_START_BIT 3'd0

// Reset values of the two views.
`define STATUS_RESET 8'h08
`define CONTROL_RESET 8'h00

// Supply level codes driven toward the supply regulator.
`define SUPPLY_3V 2'h0
`define SUPPLY_5V 2'h1
`define SUPPLY_1V8 2'h2

// Low-power clock setting codes.
`define LPCLK_STOP_LOW 2'h0
`define LPCLK_STOP_HIGH 2'h1
`define LPCLK_INT_OSC 2'h2

// Card clock half periods in system clock cycles.
`define DIV_HALF_1 8'h01
`define DIV_HALF_2 8'h02
`define DIV_HALF_4 8'h04
`define DIV_HALF_5 8'h05
`define DIV_HALF_INTOSC 8'h08

`endif

// ### hdl/sticky_flag.v
// Sticky event flag whose set wins over a simultaneous clear.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
    parameter RESET_VALUE = 1'b0
) (
    input wire clk_sys,  // System clock.
    input wire rst_n,    // Synchronous reset, active low.
    input wire setEvent, // One-cycle event that raises the flag.
    input wire clearReq, // Clear after a completed status read.
    output reg flag_reg  // Current flag value.
);
    // A clear never hides an event of the same cycle, so no event is lost.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            flag_reg <= RESET_VALUE;
        end else if (setEvent) begin
            flag_reg <= 1'b1;
        end else if (clearReq) begin
            flag_reg <= 1'b0;
        end
    end
endmodule // sticky_flag
`default_nettype wire

// ### hdl/card_clock_gen.v
// Card clock generator: divided clock, stopped level or fallback clock.
`timescale 1ns/1ps
`default_nettype none
`include "card_slot_regs.vh"
module card_clock_gen (
    input wire clk_sys,              // System clock.
    input wire rst_n,                // Synchronous reset, active low.
    input wire clockStopApply,       // Use low-power setting when high.
    input wire [1:0] lowpowerSetting, // Low-power clock choice.
    input wire [1:0] dividerSetting, // Divider choice for normal running.
    input wire enable,               // Slot active; clock held low otherwise.
    output reg cardClock_reg,        // Card clock output.
    output reg fallback_reg          // Internal oscillator clock in use.
);
    reg [7:0] halfCount_reg; // Counts system cycles within a half period.
    reg [7:0] halfLimit;     // Half period for the current choice.
    reg running;             // Clock toggles rather than holds.
    reg holdLevel;           // Level held while stopped.

    // Pick the divider and the stop level from the current settings.
    always @* begin
        halfLimit = `DIV_HALF_1;
        running = enable;
        holdLevel = 1'b0;
        if (clockStopApply) begin
            case (lowpowerSetting)
                `LPCLK_STOP_HIGH: begin
                    running = 1'b0;
                    holdLevel = 1'b1;
                end
                `LPCLK_INT_OSC: halfLimit = `DIV_HALF_INTOSC;
                default: running = 1'b0;
            endcase
        end else begin
            case (dividerSetting)
                2'h1: halfLimit = `DIV_HALF_2;
                2'h2: halfLimit = `DIV_HALF_4;
                2'h3: halfLimit = `DIV_HALF_5;
                default: halfLimit = `DIV_HALF_1;
            endcase
        end
    end

    // Toggle on half-period boundaries so ratio changes land on an edge.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            halfCount_reg <= 8'h00;
            cardClock_reg <= 1'b0;
            fallback_reg <= 1'b0;
        end else begin
            fallback_reg <= clockStopApply && (lowpowerSetting == `LPCLK_INT_OSC);
            if (!running || !enable) begin
                halfCount_reg <= 8'h00;
                cardClock_reg <= enable ? holdLevel : 1'b0;
            end else if (halfCount_reg + 8'h01 >= halfLimit) begin
                halfCount_reg <= 8'h00;
                cardClock_reg <= ~cardClock_reg;
            end else begin
                halfCount_reg <= halfCount_reg + 8'h01;
            end
        end
    end
endmodule // card_clock_gen
`default_nettype wire

// ### bench/host_model.sv
// Host model: control byte writes and whole status byte reads.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_sys, // System clock.
    input wire logic [7:0] statusByte, // Status view of the slot.
    output var logic regWrite, // Control write strobe.
    output var logic [7:0] regWriteData, // Control byte.
    output var logic statusReadDone // Status byte fully sent.
);
    // Idle bus at time zero.
    initial begin
        regWrite = 1'b0;
        regWriteData = 8'h00;
        statusReadDone = 1'b0;
    end

    // One write; released data is inverted so nothing leans on a stale byte.
    task automatic writeCtl(input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regWriteData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regWriteData <= ~d;
    endtask

    // Capture, shift out eight bit times, then report the byte complete.
    task automatic readStatus(output logic [7:0] v);
        @(posedge clk_sys);
        v = statusByte;
        repeat (8) @(posedge clk_sys);
        statusReadDone <= 1'b1;
        @(posedge clk_sys);
        statusReadDone <= 1'b0;
    endtask
endmodule // host_model
`default_nettype wire

// ### bench/card_slot_status_control_reg_assertions.sv
// Port assertions for the card slot status and control register.
`timescale 1ns/1ps
`default_nettype none
module card_slot_status_control_reg_assertions (
    input wire logic clk_sys, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic regWrite, // Write strobe.
    input wire logic [7:0] regWriteData, // Write byte.
    input wire logic statusReadDone, // Read done.
    input wire logic cardPresent, // Presence.
    input wire logic earlyAnswerEvent, // Early answer.
    input wire logic muteEvent, // Mute.
    input wire logic overloadEvent, // Overload.
    input wire logic supplyFaultEvent, // Supply fault.
    input wire logic startBitDetected, // Start bit.
    input wire logic [7:0] statusByte, // Status view.
    input wire logic interruptRequest_n, // Interrupt.
    input wire logic [1:0] supplyLevel, // Supply code.
    input wire logic supplyOn, // Supply on.
    input wire logic [1:0] pageViewSelect, // Page view.
    input wire logic warmResetActive, // Warm reset.
    input wire logic coldStartPulse // Start pulse.
);
    // High when none of the early, mute, overload or supply events pulses this cycle.
    wire quiet = !(earlyAnswerEvent | muteEvent | overloadEvent | supplyFaultEvent);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_irq_flag_tie: assert property ($past(rst_n) && $past(rst_n, 2) |->
        interruptRequest_n == !(|statusByte[6:3] || statusByte[1]))
        else $error("interrupt does not match flags");
    a_read_clears: assert property (statusReadDone && quiet && $stable(cardPresent)
        |-> ##2 (statusByte[6:3] == 4'h0 && !statusByte[1]))
        else $error("flags not cleared by read");
    a_supply_sets: assert property (supplyFaultEvent |-> ##2 statusByte[3])
        else $error("supply flag not set");
    a_start_refused: assert property (regWrite && regWriteData[0] && statusByte[3]
        && !statusByte[7] && !$past(statusReadDone) && !$past(regWrite) |-> ##2 !statusByte[7])
        else $error("start taken despite fault");
    a_start_active: assert property (coldStartPulse |=> statusByte[7] && supplyOn)
        else $error("start did not activate");
    a_supply_code: assert property (regWrite && !statusByte[7] && !coldStartPulse
        |-> ##2 supplyLevel == ($past(regWriteData[7], 2) ? 2'h2 : {1'b0, $past(regWriteData[2], 2)}))
        else $error("wrong supply code");
    a_page_follow: assert property (regWrite |->
        ##2 pageViewSelect == $past(regWriteData[5:4], 2))
        else $error("page view not written");
    a_warm_start: assert property (startBitDetected && !regWrite |-> ##2 !warmResetActive)
        else $error("warm reset not ended by start bit");
    a_warm_mute: assert property (muteEvent && !regWrite |-> ##2 !warmResetActive)
        else $error("warm reset not ended by mute");
    a_write_keeps: assert property (regWrite && quiet && !statusReadDone && $stable(cardPresent)
        |-> ##2 {statusByte[6:3], statusByte[1]} == $past({statusByte[6:3], statusByte[1]}))
        else $error("write changed a flag");
endmodule // card_slot_status_control_reg_assertions
bind card_slot_status_control_reg card_slot_status_control_reg_assertions
    card_slot_status_control_reg_assertions_i (.clk_sys, .rst_n, .regWrite, .regWriteData,
    .statusReadDone, .cardPresent, .earlyAnswerEvent, .muteEvent, .overloadEvent,
    .supplyFaultEvent, .startBitDetected, .statusByte, .interruptRequest_n, .supplyLevel,
    .supplyOn, .pageViewSelect, .warmResetActive, .coldStartPulse);
`default_nettype wire

// ### bench/test_card_slot_status_control_reg.sv
// Self-checking bench for the card slot status and control register.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin badCount++; $display("FAIL %s exp %h got %h", n, e, g); end end
module test_card_slot_status_control_reg;
    reg clk_sys = 1'b0; // System clock.
    reg rst_n = 1'b0; // Reset, active low.
    reg cardPresent = 1'b0; // Card presence level.
    reg [4:0] ev = 5'h00; // Pulses: early, mute, overload, supply, start bit.
    reg [1:0] lowpowerClockSetting = 2'h0; // Power-down clock choice.
    reg [1:0] clockDividerSetting = 2'h0; // Divider choice.
    reg hostExt = 1'b1; // Level the host puts on its line.
    reg cardExt = 1'b1; // Level the card puts on its line.
    wire regWrite, statusReadDone, supplyOn, warmResetActive, coldStartPulse, deactivatePulse;
    wire interruptRequest_n, cardClock, hostIoOut, hostIoOe, cardIoOut, cardIoOe;
    wire [7:0] regWriteData, statusByte;
    wire [1:0] supplyLevel, pageViewSelect;
    // Pulled-up lines: low whenever some party drives low.
    wire hostIoIn = hostExt & ~(hostIoOe & ~hostIoOut);
    wire cardIoIn = cardExt & ~(cardIoOe & ~cardIoOut);
    int compares = 0; // Comparisons made.
    int badCount = 0; // Mismatches seen.
    int n, p; // Loop index and measured period.
    reg [15:0] rnd = 16'hFC80; // Random state.
    reg [7:0] got; // Byte taken by the host.

    card_slot_status_control_reg card_slot_status_control_reg_i (.clk_sys, .rst_n, .regWrite,
        .regWriteData, .statusReadDone, .cardPresent, .earlyAnswerEvent(ev[0]),
        .muteEvent(ev[1]), .overloadEvent(ev[2]), .supplyFaultEvent(ev[3]),
        .startBitDetected(ev[4]), .lowpowerClockSetting, .clockDividerSetting, .hostIoIn,
        .cardIoIn, .statusByte, .interruptRequest_n, .supplyLevel, .supplyOn, .pageViewSelect,
        .warmResetActive, .coldStartPulse, .deactivatePulse, .cardClock, .hostIoOut, .hostIoOe,
        .cardIoOut, .cardIoOe);
    host_model host_model_i (.clk_sys, .statusByte, .regWrite, .regWriteData, .statusReadDone);

    // 200 MHz clock.
    always #2.5 clk_sys = ~clk_sys;

    // Sixteen-bit feedback shift register for repeatable stimulus.
    function automatic [15:0] nextRnd(input [15:0] s);
        nextRnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Supply code that a control byte asks for when accepted.
    function automatic [1:0] expSupply(input [7:0] d);
        expSupply = d[7] ? 2'h2 : {1'b0, d[2]};
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic wrapUp;
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // One-cycle event pulse on line b; the whole event word is driven each time.
    task automatic pulse(input int b);
        @(posedge clk_sys);
        ev <= 5'h01 << b;
        @(posedge clk_sys);
        ev <= 5'h00;
    endtask

    // Cycles between two rising card clock edges; 0 if none within the bound.
    task automatic period(output int q);
        int k;
        int first;
        reg prev;
        first = -1;
        q = 0;
        prev = cardClock;
        for (k = 0; k < 60 && q == 0; k++) begin
            @(posedge clk_sys);
            if (prev === 1'b0 && cardClock === 1'b1) begin
                if (first < 0) first = k;
                else q = k - first;
            end
            prev = cardClock;
        end
    endtask

    // Cuts a hang short; the tests need well under a thousand cycles.
    initial begin
        cyc(5000);
        badCount++;
        $display("FAIL watchdog expired");
        wrapUp;
    end

    // Main sequence.
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        `CHK("status", 8'h08, statusByte)
        `CHK("irq", 1'b0, interruptRequest_n)
        cardPresent <= 1'b1;
        cyc(4);
        // Start is refused while the supply flag from power-up stands.
        host_model_i.writeCtl(8'h01);
        cyc(3);
        `CHK("status", 8'h0B, statusByte)
        host_model_i.readStatus(got);
        `CHK("read", 8'h0B, got)
        cyc(3);
        `CHK("status", 8'h01, statusByte)
        `CHK("irq", 1'b1, interruptRequest_n)
        // Supply and page choices: corners first, then random bytes.
        for (n = 0; n < 12; n++) begin
            rnd = nextRnd(rnd);
            got = n < 4 ? 8'(32'h84800400 >> (24 - 8 * n)) : rnd[7:0] & 8'hFC;
            clockDividerSetting <= rnd[9:8];
            host_model_i.writeCtl(got);
            cyc(3);
            `CHK("supply", expSupply(got), supplyLevel)
            `CHK("page", got[5:4], pageViewSelect)
        end
        // Pass-through: a low card line is copied to the host line.
        host_model_i.writeCtl(8'h40);
        cardExt <= 1'b0;
        cyc(4);
        `CHK("hostIo", 1'b0, hostIoIn)
        cardExt <= 1'b1;
        // And the other way: a low host line is copied to the card line.
        hostExt <= 1'b0;
        cyc(4);
        `CHK("cardIo", 1'b0, cardIoIn)
        hostExt <= 1'b1;
        host_model_i.writeCtl(8'h00);
        cyc(3);
        `CHK("ioOe", 2'b00, {hostIoOe, cardIoOe})
        host_model_i.writeCtl(8'h01);
        cyc(3);
        `CHK("active", 2'b11, {statusByte[7], supplyOn})
        for (n = 0; n < 4; n++) begin
            clockDividerSetting <= 2'(n);
            cyc(12);
            period(p);
            `CHK("divPeriod", n == 3 ? 10 : 2 << n, p)
        end
        for (n = 0; n < 4; n++) begin
            lowpowerClockSetting <= 2'(n);
            host_model_i.writeCtl(8'h09);
            cyc(20);
            period(p);
            `CHK("lpPeriod", n == 2 ? 16 : 0, p)
            `CHK("fallback", n == 2, statusByte[2])
            if (n != 2) `CHK("lpLevel", n == 1, cardClock)
        end
        host_model_i.writeCtl(8'h01);
        cyc(3);
        `CHK("fallback", 1'b0, statusByte[2])
        // Writing start clear ends the session, then it is started again.
        host_model_i.writeCtl(8'h00);
        cyc(1);
        `CHK("stopPulse", 1'b1, deactivatePulse)
        host_model_i.writeCtl(8'h01);
        // Warm reset ended by a start bit, then by a mute timeout.
        for (n = 4; n > 0; n -= 3) begin
            host_model_i.writeCtl(8'h03);
            cyc(3);
            `CHK("warm", 1'b1, warmResetActive)
            pulse(n);
            cyc(3);
            `CHK("warm", 1'b0, warmResetActive)
        end
        // Early answer lands in the very cycle the read completes.
        fork
            host_model_i.readStatus(got);
            begin
                cyc(9);
                ev[0] <= 1'b1;
                cyc(1);
                ev[0] <= 1'b0;
            end
        join
        `CHK("read", 8'hA1, got)
        cyc(3);
        `CHK("status", 8'hC1, statusByte)
        `CHK("irq", 1'b0, interruptRequest_n)
        pulse(2);
        cyc(1);
        `CHK("forcedStop", 1'b1, deactivatePulse)
        cyc(2);
        `CHK("status", 8'h51, statusByte)
        cardPresent <= 1'b0;
        pulse(3);
        cyc(4);
        `CHK("status", 8'h5A, statusByte)
        wrapUp;
    end
endmodule // test_card_slot_status_control_reg
`default_nettype wire
